// File: mre_params.svh
// Constants of the memory reference execution unit.
`ifndef MRE_PARAMS_SVH
`define MRE_PARAMS_SVH
`define MRE_OPC_HI 15
`define MRE_OPC_LO 11
`define MRE_MODE_X 10
`define MRE_MODE_I 9
`define MRE_MODE_B 8
`define MRE_PC_RESET 16'h0000
`define MRE_MPY_MAX 32'sh00007FFF
`define MRE_STORE_ZERO_OP 5'h00
`define MRE_STORE_ACCUMULATOR_OP 5'h01
`define MRE_STORE_TEMP_OP 5'h02
`define MRE_STORE_INDEX_OP 5'h03
`define MRE_STORE_DOUBLE_OP 5'h04
`define MRE_LOAD_DOUBLE_OP 5'h05
`define MRE_STORE_FLOAT_OP 5'h06
`define MRE_LOAD_FLOAT_OP 5'h07
`define MRE_INCREMENT_SKIP_OP 5'h08
`define MRE_LOAD_ACCUMULATOR_OP 5'h09
`define MRE_LOAD_TEMP_OP 5'h0A
`define MRE_LOAD_INDEX_OP 5'h0B
`define MRE_ADD_OP 5'h0C
`define MRE_SUBTRACT_OP 5'h0D
`define MRE_AND_OP 5'h0E
`define MRE_INCLUSIVE_OR_OP 5'h0F
`define MRE_FLOAT_ADD_OP 5'h10
`define MRE_FLOAT_SUBTRACT_OP 5'h11
`define MRE_FLOAT_MULTIPLY_OP 5'h12
`define MRE_FLOAT_DIVIDE_OP 5'h13
`define MRE_INTEGER_MULTIPLY_OP 5'h14
`define MRE_UNCONDITIONAL_JUMP_OP 5'h15
`define MRE_CONDITIONAL_BRANCH_GROUP 5'h16
`define MRE_CALL_LINK_OP 5'h17
`define MRE_BRANCH_ACC_NONNEG 3'h0
`define MRE_BRANCH_ACC_NEGATIVE 3'h1
`define MRE_BRANCH_ACC_ZERO 3'h2
`define MRE_BRANCH_ACC_NONZERO 3'h3
`define MRE_COUNT_BRANCH_NONNEG 3'h4
`define MRE_COUNT_BRANCH_NEGATIVE 3'h5
`define MRE_BRANCH_INDEX_ZERO 3'h6
`define MRE_BRANCH_INDEX_NEGATIVE 3'h7
`endif

// File: mre_pkg.sv
// Types of the memory reference execution unit.
package mre_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_INDIR, ST_ACCESS, ST_FLOAT} mre_state_type;
    typedef struct packed {
        mre_state_type state;
        logic [15:0]   ir;
        logic [15:0]   pc;
        logic [15:0]   acc;
        logic [15:0]   tmp;
        logic [15:0]   idx;
        logic [15:0]   dext;
        logic [15:0]   link;
        logic [15:0]   ea;
        logic [15:0]   w0;
        logic [15:0]   w1;
        logic [15:0]   w2;
        logic [1:0]    wi;
        logic          carry;
        logic          ovd;
        logic          ovs;
        logic          guard;
        logic          errz;
        logic          done;
        logic          illegal;
        logic          fstart;
        logic          mreq;
        logic          mwe;
        logic [15:0]   maddr;
        logic [15:0]   mwdata;
    } mre_regs_type;
endpackage : mre_pkg

// File: mre_exec.sv
// Memory reference instruction execution unit.
// Operation
// - Store-zero writes zero, registers untouched.
// - Store accumulator, temporary or index word.
// - Double store: accumulator, then extension at plus one.
// - Float store: exponent word first, three words.
// - Increment memory, skip next when zero.
// - Load accumulator, temporary or index only.
// - Double load: accumulator, then extension.
// - Float load into temporary, accumulator, extension.
// - Add sets carry from sign position.
// - Overflow sets both; else clears dynamic only.
// - Subtract adds two's complement, same indicators.
// - AND and OR change accumulator only.
// - Signed multiply, overflow beyond 32767.
// - Float add/subtract update accumulator and guard.
// - Float multiply/divide update floating accumulator.
// - Float divide by zero sets error.
// - Jump loads effective address into counter.
// - Call saves next address in link.
// - Bits 8-10 pick condition; signed displacement.
// - Accumulator sign and zero branch tests.
// - Index negative and zero branch tests.
// - Count branches increment index then test.
// - Base relative: displacement plus base.
// - Indirect: fetched word becomes the address.
// - Base indexed: index plus base plus displacement.
// - Indirect indexed: index added after indirection.
`timescale 1ns/10ps
`default_nettype none
`include "mre_params.svh"
module mre_exec (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic [15:0] instr,
    input  wire logic [15:0] base_value,
    output logic             busy,
    output logic             done,
    output logic             illegal,
    output logic [15:0]      pc,
    output logic [15:0]      acc,
    output logic [15:0]      tmp,
    output logic [15:0]      index,
    output logic [15:0]      dext,
    output logic [15:0]      link,
    output logic             carry,
    output logic             ovf_dynamic,
    output logic             ovf_static,
    output logic             float_guard_bit,
    output logic             error_z,
    output logic             mem_req,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic             fp_start,
    output logic [1:0]       fp_op,
    output logic [15:0]      fp_operand0,
    output logic [15:0]      fp_operand1,
    output logic [15:0]      fp_operand2,
    input  wire logic        fp_done,
    input  wire logic [15:0] fp_result0,
    input  wire logic [15:0] fp_result1,
    input  wire logic [15:0] fp_result2,
    input  wire logic        fp_guard
);
    mre_pkg::mre_regs_type s_reg;
    mre_pkg::mre_regs_type s_next;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    function automatic logic [15:0] store_word(input logic [4:0] op, input logic [1:0] wi);
        case (op)
            `MRE_STORE_ACCUMULATOR_OP: store_word = s_reg.acc;
            `MRE_STORE_TEMP_OP:        store_word = s_reg.tmp;
            `MRE_STORE_INDEX_OP:       store_word = s_reg.idx;
            `MRE_STORE_DOUBLE_OP:      store_word = (wi == 2'h0) ? s_reg.acc : s_reg.dext;
            `MRE_STORE_FLOAT_OP:
                store_word = (wi == 2'h0) ? s_reg.tmp : ((wi == 2'h1) ? s_reg.acc : s_reg.dext);
            default:                   store_word = 16'h0000;
        endcase
    endfunction : store_word

    always_comb begin
        logic [15:0] cur;
        logic [4:0]  op;
        logic [15:0] dsp;
        logic [15:0] xoff;
        logic [15:0] pre;
        logic [15:0] eav;
        logic [15:0] opd;
        logic [16:0] sum;
        logic signed [31:0] prod;
        logic [1:0]  last;
        logic        go;
        logic        finish;
        logic        skip;
        logic        unconditional_jump_op;
        logic        take;
        logic        flt;
        logic        ov;
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.illegal = 1'b0;
        s_next.fstart = 1'b0;
        cur = (s_reg.state == mre_pkg::ST_IDLE) ? instr : s_reg.ir;
        op = cur[`MRE_OPC_HI:`MRE_OPC_LO];
        dsp = {{8{cur[7]}}, cur[7:0]};
        xoff = cur[`MRE_MODE_X] ? s_reg.idx : 16'h0000;
        pre = dsp + (cur[`MRE_MODE_B] ? base_value : s_reg.pc);
        eav = 16'h0000;
        opd = (op == `MRE_SUBTRACT_OP) ? ~mem_rdata : mem_rdata;
        sum = {1'b0, s_reg.acc} + {1'b0, opd} + {16'h0000, op == `MRE_SUBTRACT_OP};
        prod = $signed(s_reg.acc) * $signed(mem_rdata);
        ov = 1'b0;
        go = 1'b0;
        finish = 1'b0;
        skip = 1'b0;
        unconditional_jump_op = 1'b0;
        take = 1'b0;
        flt = op >= `MRE_FLOAT_ADD_OP && op <= `MRE_FLOAT_DIVIDE_OP;
        if (op == `MRE_STORE_DOUBLE_OP || op == `MRE_LOAD_DOUBLE_OP || op == `MRE_INCREMENT_SKIP_OP) begin
            last = 2'h1;
        end else if (flt || op == `MRE_STORE_FLOAT_OP || op == `MRE_LOAD_FLOAT_OP) begin
            last = 2'h2;
        end else begin
            last = 2'h0;
        end
        case (s_reg.state)
            mre_pkg::ST_IDLE: if (start) begin
                s_next.ir = instr;
                if (op == `MRE_CONDITIONAL_BRANCH_GROUP) begin
                    // Mode bits name the condition here, so the target is always the counter plus displacement.
                    case (cur[10:8])
                        `MRE_BRANCH_ACC_NONNEG:    take = ~s_reg.acc[15];
                        `MRE_BRANCH_ACC_NEGATIVE:  take = s_reg.acc[15];
                        `MRE_BRANCH_ACC_ZERO:      take = s_reg.acc == 16'h0000;
                        `MRE_BRANCH_ACC_NONZERO:   take = s_reg.acc != 16'h0000;
                        `MRE_BRANCH_INDEX_ZERO:    take = s_reg.idx == 16'h0000;
                        `MRE_BRANCH_INDEX_NEGATIVE: take = s_reg.idx[15];
                        default: begin
                            s_next.idx = s_reg.idx + 16'h0001;
                            take = s_next.idx[15] == cur[8];
                        end
                    endcase
                    finish = 1'b1;
                    unconditional_jump_op = take;
                    eav = s_reg.pc + dsp;
                end else if (op > `MRE_CALL_LINK_OP) begin
                    s_next.illegal = 1'b1;
                    finish = 1'b1;
                end else if (cur[`MRE_MODE_I]) begin
                    s_next.state = mre_pkg::ST_INDIR;
                    s_next.mreq = 1'b1;
                    s_next.mwe = 1'b0;
                    s_next.maddr = pre;
                end else begin
                    go = 1'b1;
                    // Plain X mode drops the counter, so P is added only without X and B.
                    eav = dsp + xoff + (cur[`MRE_MODE_B] ? base_value : (cur[`MRE_MODE_X] ? 16'h0000 : s_reg.pc));
                end
            end
            mre_pkg::ST_INDIR: if (mem_ack) begin
                s_next.mreq = 1'b0;
                go = 1'b1;
                eav = mem_rdata + xoff;
            end
            mre_pkg::ST_ACCESS: if (mem_ack) begin
                if (s_reg.mwe) begin
                    if (op == `MRE_INCREMENT_SKIP_OP) begin
                        finish = 1'b1;
                        skip = s_reg.mwdata == 16'h0000;
                    end else if (s_reg.wi == last) begin
                        finish = 1'b1;
                    end else begin
                        s_next.wi = s_reg.wi + 2'h1;
                        s_next.maddr = s_reg.maddr + 16'h0001;
                        s_next.mwdata = store_word(op, s_next.wi);
                    end
                end else begin
                    case (op)
                        `MRE_INCREMENT_SKIP_OP: begin
                            s_next.mwe = 1'b1;
                            s_next.mwdata = mem_rdata + 16'h0001;
                        end
                        `MRE_LOAD_ACCUMULATOR_OP: s_next.acc = mem_rdata;
                        `MRE_LOAD_TEMP_OP:        s_next.tmp = mem_rdata;
                        `MRE_LOAD_INDEX_OP:       s_next.idx = mem_rdata;
                        `MRE_LOAD_DOUBLE_OP: begin
                            if (s_reg.wi == 2'h0) begin
                                s_next.acc = mem_rdata;
                            end else begin
                                s_next.dext = mem_rdata;
                            end
                        end
                        `MRE_LOAD_FLOAT_OP: begin
                            if (s_reg.wi == 2'h0) begin
                                s_next.tmp = mem_rdata;
                            end else if (s_reg.wi == 2'h1) begin
                                s_next.acc = mem_rdata;
                            end else begin
                                s_next.dext = mem_rdata;
                            end
                        end
                        `MRE_ADD_OP, `MRE_SUBTRACT_OP: begin
                            s_next.acc = sum[15:0];
                            s_next.carry = sum[16];
                            ov = (s_reg.acc[15] == opd[15]) && (sum[15] != s_reg.acc[15]);
                        end
                        `MRE_AND_OP:          s_next.acc = s_reg.acc & mem_rdata;
                        `MRE_INCLUSIVE_OR_OP: s_next.acc = s_reg.acc | mem_rdata;
                        `MRE_INTEGER_MULTIPLY_OP: begin
                            s_next.acc = prod[15:0];
                            ov = prod > `MRE_MPY_MAX || prod < -`MRE_MPY_MAX;
                        end
                        default: begin
                            if (s_reg.wi == 2'h0) begin
                                s_next.w0 = mem_rdata;
                            end else if (s_reg.wi == 2'h1) begin
                                s_next.w1 = mem_rdata;
                            end else begin
                                s_next.w2 = mem_rdata;
                                s_next.mreq = 1'b0;
                                // A zero mantissa divisor is refused before the float unit sees it.
                                if (op == `MRE_FLOAT_DIVIDE_OP && s_reg.w1 == 16'h0000 && mem_rdata == 16'h0000) begin
                                    s_next.errz = 1'b1;
                                    finish = 1'b1;
                                end else begin
                                    s_next.state = mre_pkg::ST_FLOAT;
                                    s_next.fstart = 1'b1;
                                end
                            end
                        end
                    endcase
                    if (op == `MRE_ADD_OP || op == `MRE_SUBTRACT_OP || op == `MRE_INTEGER_MULTIPLY_OP) begin
                        s_next.ovd = ov;
                        s_next.ovs = s_reg.ovs | ov;
                    end
                    if (op != `MRE_INCREMENT_SKIP_OP) begin
                        if (s_reg.wi == last) begin
                            finish = finish | ~flt;
                        end else begin
                            s_next.wi = s_reg.wi + 2'h1;
                            s_next.maddr = s_reg.maddr + 16'h0001;
                        end
                    end
                end
            end
            mre_pkg::ST_FLOAT: if (fp_done) begin
                s_next.tmp = fp_result0;
                s_next.acc = fp_result1;
                s_next.dext = fp_result2;
                s_next.guard = fp_guard;
                finish = 1'b1;
            end
            default: s_next.state = mre_pkg::ST_IDLE;
        endcase
        if (go) begin
            s_next.ea = eav;
            if (op == `MRE_UNCONDITIONAL_JUMP_OP || op == `MRE_CALL_LINK_OP) begin
                unconditional_jump_op = 1'b1;
                finish = 1'b1;
                if (op == `MRE_CALL_LINK_OP) begin
                    s_next.link = s_reg.pc + 16'h0001;
                end
            end else begin
                s_next.state = mre_pkg::ST_ACCESS;
                s_next.wi = 2'h0;
                s_next.mreq = 1'b1;
                s_next.mwe = op <= `MRE_STORE_FLOAT_OP && op != `MRE_LOAD_DOUBLE_OP;
                s_next.maddr = eav;
                s_next.mwdata = store_word(op, 2'h0);
            end
        end
        if (finish) begin
            s_next.state = mre_pkg::ST_IDLE;
            s_next.mreq = 1'b0;
            s_next.mwe = 1'b0;
            s_next.done = 1'b1;
            s_next.pc = unconditional_jump_op ? eav : s_reg.pc + (skip ? 16'h0002 : 16'h0001);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
            s_reg.pc <= `MRE_PC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.state != mre_pkg::ST_IDLE;
    assign done = s_reg.done;
    assign illegal = s_reg.illegal;
    assign pc = s_reg.pc;
    assign acc = s_reg.acc;
    assign tmp = s_reg.tmp;
    assign index = s_reg.idx;
    assign dext = s_reg.dext;
    assign link = s_reg.link;
    assign carry = s_reg.carry;
    assign ovf_dynamic = s_reg.ovd;
    assign ovf_static = s_reg.ovs;
    assign float_guard_bit = s_reg.guard;
    assign error_z = s_reg.errz;
    assign mem_req = s_reg.mreq;
    assign mem_we = s_reg.mwe;
    assign mem_addr = s_reg.maddr;
    assign mem_wdata = s_reg.mwdata;
    assign fp_start = s_reg.fstart;
    assign fp_op = s_reg.ir[12:11];
    assign fp_operand0 = s_reg.w0;
    assign fp_operand1 = s_reg.w1;
    assign fp_operand2 = s_reg.w2;

    chk_store_zero_word: assert property (mem_req && mem_we && s_reg.ir[15:11] == `MRE_STORE_ZERO_OP
        |-> mem_wdata == 16'h0000) else $error("store zero wrote nonzero data");
    chk_double_second_addr: assert property (mem_req && mem_we && s_reg.ir[15:11] == `MRE_STORE_DOUBLE_OP
        && s_reg.wi == 2'h1 |-> mem_addr == s_reg.ea + 16'h0001 && mem_wdata == dext)
        else $error("double store second word wrong");
    chk_increment_skip: assert property (mem_req && mem_we && mem_ack && s_reg.ir[15:11] == `MRE_INCREMENT_SKIP_OP
        |=> pc == $past(pc) + ((($past(mem_wdata)) == 16'h0000) ? 16'h0002 : 16'h0001))
        else $error("increment skip counter wrong");
    chk_add_result: assert property (mem_ack && !mem_we && s_reg.state == mre_pkg::ST_ACCESS
        && s_reg.ir[15:11] == `MRE_ADD_OP |=> acc == $past(acc) + $past(mem_rdata)) else $error("add result wrong");
    chk_overflow_static: assert property (ovf_dynamic |-> ovf_static)
        else $error("dynamic overflow without static overflow");
    chk_divzero_cause: assert property ($rose(error_z) |-> $past(s_reg.ir[15:11]) == `MRE_FLOAT_DIVIDE_OP)
        else $error("error indicator set outside float divide");
    chk_jump_target: assert property (done && s_reg.ir[15:11] == `MRE_UNCONDITIONAL_JUMP_OP
        |-> pc == s_reg.ea) else $error("jump did not reach effective address");
    chk_call_link: assert property (done && s_reg.ir[15:11] == `MRE_CALL_LINK_OP
        |-> link == $past(pc) + 16'h0001 || $past(busy)) else $error("link not next address");
    chk_branch_zero: assert property (start && !busy && instr[15:8] == 8'hB2 && acc == 16'h0000
        |=> done && pc == $past(pc) + {{8{$past(instr[7])}}, $past(instr[7:0])})
        else $error("accumulator zero branch wrong");
    chk_count_index: assert property (start && !busy && instr[15:11] == `MRE_CONDITIONAL_BRANCH_GROUP
        && instr[10:9] == 2'h2 |=> index == $past(index) + 16'h0001) else $error("count branch index not stepped");
    cov_skip_taken: cover property (done && pc == $past(pc) + 16'h0002);
    cov_indirect: cover property (s_reg.state == mre_pkg::ST_INDIR && mem_ack);
    cov_float_run: cover property (fp_start ##[1:20] done);
    cov_overflow: cover property ($rose(ovf_static));
endmodule : mre_exec
`default_nettype wire

// File: mre_mem_model.sv
// Word-wide main memory that answers the unit's request port.
`timescale 1ns/10ps
`default_nettype none
module mre_mem_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    logic [15:0] m [0:65535];
    logic [1:0]  wait_reg;
    logic [15:0] last_reg;
    // Outside a read answer the data bus shows the inverse of the last bus word, so after a write answer the stale read word shows again.
    assign mem_ack   = mem_req && (wait_reg == (slow ? 2'h2 : 2'h0));
    assign mem_rdata = (mem_ack && !mem_we) ? m[mem_addr] : ~last_reg;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg <= 2'h0;
            last_reg <= 16'h0000;
        end else if (mem_ack) begin
            wait_reg <= 2'h0;
            last_reg <= mem_rdata;
            if (mem_we) m[mem_addr] <= mem_wdata;
        end else if (mem_req) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule : mre_mem_model
`default_nettype wire

// File: memory_reference_exec_unit_tb_top.sv
// Self-checking bench of the memory reference execution unit.
`timescale 1ns/10ps
`default_nettype none
`include "mre_params.svh"
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module memory_reference_exec_unit_tb_top;
    logic clock = 1'b0, reset_n = 1'b0, start = 1'b0, slow = 1'b0, fp_done = 1'b0, fp_guard = 1'b0;
    logic busy, done, illegal, carry, ovf_dynamic, ovf_static, float_guard_bit, error_z, mem_req, mem_we, mem_ack;
    logic fp_start, c_e, od_e, os_e;
    logic [1:0] fp_op;
    logic [7:0] d;
    logic [17:0] r;
    logic [15:0] instr = 16'h0000, base_value = 16'h0000, fp_result0 = 16'h0000, fp_result1 = 16'h0000;
    logic [15:0] fp_result2 = 16'h0000, pc, acc, tmp, index, dext, link, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] fp_operand0, fp_operand1, fp_operand2, lf = 16'h0032, pc_e, a_e, t_e, x_e, d_e, b, w, ea, q, nx;
    int failures = 0, n_tests = 0, k, i;
    mre_exec uut (.clock, .reset_n, .start, .instr, .base_value, .busy, .done, .illegal, .pc, .acc, .tmp, .index,
        .dext, .link, .carry, .ovf_dynamic, .ovf_static, .float_guard_bit, .error_z, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .fp_start, .fp_op, .fp_operand0, .fp_operand1, .fp_operand2, .fp_done,
        .fp_result0, .fp_result1, .fp_result2, .fp_guard);
    mre_mem_model mem (.clock, .reset_n, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    // The float stand-in inverts the operand words and marks the operation code in the last word.
    always @(posedge clock) begin
        fp_done <= fp_start;
        {fp_result0, fp_result1, fp_result2} <= ~{fp_operand0, fp_operand1, fp_operand2} ^ {46'h0, fp_op};
        fp_guard <= fp_operand0[0];
    end
    initial begin
        forever #10 clock = ~clock;
    end
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    function automatic logic [17:0] alu(input int op, input logic [15:0] a, input logic [15:0] v);
        logic [16:0] s;
        logic signed [31:0] p;
        s = (op == 13) ? {1'b0, a} + {1'b0, ~v} + 17'h00001 : {1'b0, a} + {1'b0, v};
        p = $signed(a) * $signed(v);
        if (op == 12) return {(a[15] == v[15]) && (s[15] != a[15]), s};
        if (op == 13) return {(a[15] != v[15]) && (s[15] != a[15]), s};
        if (op == 14) return {2'h0, a & v};
        if (op == 15) return {2'h0, a | v};
        return {(p > 32767) || (p < -32767), 1'b0, p[15:0]};
    endfunction : alu
    function automatic logic taken(input int c, input logic [15:0] a, input logic [15:0] x);
        logic [7:0] cv;
        cv = {x[15], x == 16'h0000, x[15], !x[15], a != 16'h0000, a == 16'h0000, a[15], !a[15]};
        return cv[c];
    endfunction : taken
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic ex(input logic [4:0] op, input logic [2:0] md, input logic [7:0] dp, input logic [15:0] np);
        int t;
        t = 0;
        @(posedge clock);
        #2 start = 1'b1;
        instr = {op, md, dp};
        slow = lf[0];
        @(posedge clock);
        #2 start = 1'b0;
        while (done !== 1'b1 && t < 300) begin
            @(posedge clock);
            #2 t++;
        end
        if (t >= 300) failures++;
        pc_e = np;
        nx = np + 16'h0001;
        `CHK("regs", {pc, acc, tmp, index, dext, busy}, {pc_e, a_e, t_e, x_e, d_e, 1'b0})
    endtask : ex
    initial begin
        #1000000 failures++;
        report_and_stop();
    end
    initial begin
        {pc_e, a_e, t_e, x_e, d_e, c_e, od_e, os_e} = '0;
        nx = 16'h0001;
        repeat (16) @(posedge clock);
        #2 reset_n = 1'b1;
        for (k = 0; k < 6; k++) begin
            lf = step(lf);
            b = lf;
            base_value = b;
            lf = step(lf);
            d = lf[7:0];
            ea = b + {{8{d[7]}}, d};
            w = (k == 0) ? 16'h8000 : (k == 2) ? 16'h0009 : (k == 3) ? 16'hFFF4 : step(lf);
            for (i = 9; i < 12; i++) begin
                mem.m[ea] = w ^ 16'(i);
                if (i == 9) a_e = mem.m[ea];
                else if (i == 10) t_e = mem.m[ea];
                else x_e = mem.m[ea];
                ex(i[4:0], 3'h1, d, nx);
            end
            for (i = 0; i < 8; i++) begin
                lf = step(lf);
                if (i == 4 || i == 5) x_e = x_e + 16'h0001;
                ex(`MRE_CONDITIONAL_BRANCH_GROUP, i[2:0], lf[7:0], taken(i, a_e, x_e) ? pc_e + {{8{lf[7]}}, lf[7:0]} : nx);
            end
            for (i = 0; i < 4; i++) begin
                ex(i[4:0], 3'h1, d, nx);
                `CHK("store", mem.m[ea], (i == 0) ? 16'h0000 : (i == 1) ? a_e : (i == 2) ? t_e : x_e)
            end
            for (i = 12; i < 21; i++) begin
                if (i > 15 && i < 20) continue;
                lf = step(lf);
                mem.m[ea] = (k == 1) ? 16'h7FFF : lf;
                r = alu(i, a_e, mem.m[ea]);
                a_e = r[15:0];
                if (i < 14) c_e = r[16];
                if (i < 14 || i == 20) od_e = r[17];
                os_e = os_e | r[17];
                ex(i[4:0], 3'h1, d, nx);
                `CHK("flags", {carry, ovf_dynamic, ovf_static}, {c_e, od_e, os_e})
            end
            {mem.m[ea], mem.m[ea + 16'h0001], mem.m[ea + 16'h0002]} = {w, ~w, b};
            {a_e, d_e} = {w, ~w};
            ex(`MRE_LOAD_DOUBLE_OP, 3'h1, d, nx);
            {t_e, a_e, d_e} = {w, ~w, b};
            ex(`MRE_LOAD_FLOAT_OP, 3'h1, d, nx);
            ex(`MRE_STORE_DOUBLE_OP, 3'h1, d, nx);
            `CHK("dbl", {mem.m[ea], mem.m[ea + 16'h0001]}, {~w, b})
            ex(`MRE_STORE_FLOAT_OP, 3'h1, d, nx);
            `CHK("flt", {mem.m[ea], mem.m[ea + 16'h0001], mem.m[ea + 16'h0002]}, {w, ~w, b})
            {t_e, a_e, d_e} = {~w, w, ~b};
            for (i = 16; i < 19; i++) begin
                d_e = ~b ^ 16'(i - 16);
                ex(i[4:0], 3'h1, d, nx);
            end
            `CHK("guard", float_guard_bit, w[0])
            {mem.m[ea + 16'h0001], mem.m[ea + 16'h0002]} = 32'h00000000;
            ex(`MRE_FLOAT_DIVIDE_OP, 3'h1, d, nx);
            `CHK("div_zero", error_z, 1'b1)
            for (i = 0; i < 8; i++) begin
                q = (i[0] ? b : (i[2] && !i[1]) ? 16'h0000 : pc_e) + {{8{d[7]}}, d};
                if (i[1]) begin
                    mem.m[q] = w ^ b ^ 16'(i);
                    q = mem.m[q];
                end
                q = q + (i[2] ? x_e : 16'h0000);
                mem.m[q] = ~b ^ 16'(i);
                a_e = mem.m[q];
                ex(`MRE_LOAD_ACCUMULATOR_OP, i[2:0], d, nx);
            end
            mem.m[ea] = (k == 0) ? 16'hFFFF : w;
            q = mem.m[ea] + 16'h0001;
            ex(`MRE_INCREMENT_SKIP_OP, 3'h1, d, (q == 16'h0000) ? pc_e + 16'h0002 : nx);
            `CHK("incr", mem.m[ea], q)
            ex(`MRE_UNCONDITIONAL_JUMP_OP, 3'h1, d, ea);
            q = nx;
            ex(`MRE_CALL_LINK_OP, 3'h1, d, ea);
            `CHK("link", link, q)
            ex(5'h18 + k[4:0], 3'h0, d, nx);
            `CHK("illegal", illegal, 1'b1)
        end
        report_and_stop();
    end
endmodule : memory_reference_exec_unit_tb_top
`default_nettype wire
